// *** hdl/cce_pkg.sv ***
package cce_pkg;
  // ****************
  // opcodes
  // ****************
  localparam logic [7:0] OP_CARRY_CLEAR = 8'hF8;
  localparam logic [7:0] OP_CARRY_INVERT = 8'hF5;
  localparam logic [7:0] OP_CARRY_SET = 8'hF9;
  localparam logic [7:0] OP_DIR_CLEAR = 8'hFC;
  localparam logic [7:0] OP_DIR_SET = 8'hFD;
  localparam logic [7:0] OP_IRQ_CLEAR = 8'hFA;
  localparam logic [7:0] OP_IRQ_SET = 8'hFB;
  localparam logic [7:0] OP_LOCK = 8'hF0;
  localparam logic [7:0] OP_IDLE = 8'h90;
  localparam logic [7:0] OP_HALT = 8'hF4;
  // segment override prefix 001rr110
  localparam logic [7:0] SEG_PFX_MASK = 8'hE7;
  localparam logic [7:0] SEG_PFX_VAL = 8'h26;
  localparam int SEG_PFX_LSB = 3;
  // immediate group 100000sw
  localparam logic [7:0] IMM_GRP_MASK = 8'hFC;
  localparam logic [7:0] IMM_GRP_VAL = 8'h80;
  localparam int IMM_S_BIT = 1;
  // string ops with a destination operand
  localparam logic [7:0] STR_MASK_A = 8'hFC;
  localparam logic [7:0] STR_VAL_A = 8'hA4;
  localparam logic [7:0] STR_MASK_B = 8'hFA;
  localparam logic [7:0] STR_VAL_B = 8'hAA;
  // ****************
  // mod, r/m and segment codes
  // ****************
  localparam logic [1:0] MOD_NODISP = 2'h0;
  localparam logic [1:0] MOD_DISP8 = 2'h1;
  localparam logic [1:0] MOD_DISP16 = 2'h2;
  localparam logic [1:0] MOD_REG = 2'h3;
  localparam logic [2:0] RM_DIRECT = 3'h6;
  localparam logic [1:0] SEG_EXTRA = 2'h0;
  localparam logic [1:0] SEG_CODE = 2'h1;
  localparam logic [1:0] SEG_STACK = 2'h2;
  localparam logic [1:0] SEG_DATA = 2'h3;
  // ****************
  // cycle costs
  // ****************
  localparam int CW = 6;
  localparam logic [CW-1:0] CTRL_CYC = 6'h02;
  localparam logic [CW-1:0] IDLE_CYC = 6'h03;
  localparam logic [CW-1:0] REG_OP_CYC = 6'h02;
  localparam logic [CW-1:0] MEM_OP_CYC = 6'h02;
  localparam logic [CW-1:0] EA_CYC = 6'h04;
  localparam logic [CW-1:0] WORD_XFER_CYC = 6'h04;
  typedef enum {ST_OPC, ST_MODRM, ST_DLO, ST_DHI, ST_IMM, ST_CALC, ST_EXEC, ST_HALT} cce_state_e;
endpackage : cce_pkg

// *** hdl/cce_cycle_timer.sv ***
// ****************
// countdown of instruction cycles
// ****************
module cce_cycle_timer (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic load,
  input wire logic [cce_pkg::CW-1:0] load_val,
  output logic done
);
  logic [cce_pkg::CW-1:0] count_r;

  // load, then count down to zero; done at one
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count_r <= '0;
    end else if (load) begin
      count_r <= load_val;
    end else if (count_r != '0) begin
      count_r <= count_r - 1'b1;
    end
  end

  assign done = (count_r == 6'h01);
endmodule : cce_cycle_timer

// *** hdl/cce_ea_calc.sv ***
// ****************
// effective address adder
// ****************
module cce_ea_calc (
  input wire logic [1:0] mode,
  input wire logic [2:0] rm,
  input wire logic [15:0] disp,
  input wire logic [15:0] reg_bx,
  input wire logic [15:0] reg_bp,
  input wire logic [15:0] reg_si,
  input wire logic [15:0] reg_di,
  output logic [15:0] ea,
  output logic uses_bp
);
  // base and/or index plus displacement, or direct address
  always_comb begin
    ea = disp;
    uses_bp = 1'b0;
    case (rm)
      3'h0: ea = reg_bx + reg_si + disp;
      3'h1: ea = reg_bx + reg_di + disp;
      3'h2: begin
        ea = reg_bp + reg_si + disp;
        uses_bp = 1'b1;
      end
      3'h3: begin
        ea = reg_bp + reg_di + disp;
        uses_bp = 1'b1;
      end
      3'h4: ea = reg_si + disp;
      3'h5: ea = reg_di + disp;
      3'h6: begin
        if (mode == cce_pkg::MOD_NODISP) begin
          ea = disp;
        end else begin
          ea = reg_bp + disp;
          uses_bp = 1'b1;
        end
      end
      default: ea = reg_bx + disp;
    endcase
  end
endmodule : cce_ea_calc

// *** hdl/cce_decode.sv ***
// How it works
// - F8 clears, F5 inverts, F9 sets carry; 2 cycles
// - FC clears, FD sets direction; 2 cycles
// - FA clears, FB sets irq enable; 2 cycles
// - F0 lock 2, 90 idle 3, F4 halt 2
// - word memory transfer adds four cycles
// - mode 11 selects register operand
// - mode 00 no displacement, except direct address
// - mode 01 one byte sign-extended
// - mode 10 two bytes, low first
// - codes 000-011 base plus index plus displacement
// - codes 100-111 single register plus displacement
// - displacement precedes immediate data bytes
// - address calculation costs four cycles
// - override prefix picks extra/code/stack/data segment
// - register field decode for words and bytes
// - base pointer operands default to stack segment
// - string destination always extra segment
module cce_decode (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic [15:0] reg_bx,
  input wire logic [15:0] reg_bp,
  input wire logic [15:0] reg_si,
  input wire logic [15:0] reg_di,
  input wire logic wake,
  output logic byte_ready,
  output logic carry_flag,
  output logic direction_flag,
  output logic irq_enable_flag,
  output logic halted,
  output logic bus_lock,
  output logic op_done,
  output logic [cce_pkg::CW-1:0] op_cycles,
  output logic mem_operand,
  output logic [15:0] effective_address,
  output logic [1:0] segment_sel,
  output logic [3:0] reg_sel,
  output logic [3:0] rm_reg_sel
);
  // ****************
  // helpers
  // ****************
  // register index: 0-7 word regs, 8-15 byte regs
  function automatic logic [3:0] decode_reg(input logic w, input logic [2:0] code);
    decode_reg = {~w, code};
  endfunction : decode_reg

  // byte count of displacement for a mode/rm pair
  function automatic logic [1:0] disp_bytes(input logic [1:0] mode, input logic [2:0] rm);
    case (mode)
      cce_pkg::MOD_NODISP: disp_bytes = (rm == cce_pkg::RM_DIRECT) ? 2'h2 : 2'h0;
      cce_pkg::MOD_DISP8: disp_bytes = 2'h1;
      cce_pkg::MOD_DISP16: disp_bytes = 2'h2;
      default: disp_bytes = 2'h0;
    endcase
  endfunction : disp_bytes

  // ****************
  // state
  // ****************
  cce_pkg::cce_state_e state_r;
  logic [7:0] opcode_r;
  logic [1:0] mode_r;
  logic [2:0] rm_r;
  logic [2:0] regf_r;
  logic [15:0] disp_r;
  logic [1:0] disp_left_r;
  logic [1:0] imm_left_r;
  logic ovr_valid_r;
  logic [1:0] ovr_seg_r;
  logic lock_pend_r;
  logic cur_lock_r;
  logic cur_halt_r;
  logic byte_ready_r;
  logic carry_r;
  logic direction_r;
  logic irq_enable_r;
  logic halted_r;
  logic bus_lock_r;
  logic op_done_r;
  logic [cce_pkg::CW-1:0] op_cycles_r;
  logic mem_operand_r;
  logic [15:0] ea_r;
  logic [1:0] seg_r;
  logic [3:0] reg_sel_r;
  logic [3:0] rm_reg_sel_r;

  logic accept;
  logic is_ctrl;
  logic is_seg_pfx;
  logic is_string;
  logic is_imm_grp;
  logic [1:0] imm_count;
  logic [1:0] modrm_disp;
  logic [cce_pkg::CW-1:0] ctrl_cyc;
  logic [cce_pkg::CW-1:0] mem_cyc;
  logic timer_load;
  logic [cce_pkg::CW-1:0] timer_val;
  logic timer_done;
  logic [15:0] ea_calc;
  logic ea_uses_bp;
  logic [1:0] seg_pick;

  // ****************
  // byte classification
  // ****************
  assign accept = byte_valid & byte_ready_r;
  assign is_seg_pfx = (byte_data & cce_pkg::SEG_PFX_MASK) == cce_pkg::SEG_PFX_VAL;
  assign is_string = ((byte_data & cce_pkg::STR_MASK_A) == cce_pkg::STR_VAL_A) |
                     ((byte_data & cce_pkg::STR_MASK_B) == cce_pkg::STR_VAL_B);
  assign is_imm_grp = (opcode_r & cce_pkg::IMM_GRP_MASK) == cce_pkg::IMM_GRP_VAL;
  assign imm_count = (opcode_r[0] & ~opcode_r[cce_pkg::IMM_S_BIT]) ? 2'h2 : 2'h1;
  assign modrm_disp = disp_bytes(byte_data[7:6], byte_data[2:0]);

  // fixed-cost control opcodes
  always_comb begin
    is_ctrl = 1'b1;
    ctrl_cyc = cce_pkg::CTRL_CYC;
    case (byte_data)
      cce_pkg::OP_CARRY_CLEAR, cce_pkg::OP_CARRY_INVERT, cce_pkg::OP_CARRY_SET: ctrl_cyc = cce_pkg::CTRL_CYC;
      cce_pkg::OP_DIR_CLEAR, cce_pkg::OP_DIR_SET: ctrl_cyc = cce_pkg::CTRL_CYC;
      cce_pkg::OP_IRQ_CLEAR, cce_pkg::OP_IRQ_SET: ctrl_cyc = cce_pkg::CTRL_CYC;
      cce_pkg::OP_LOCK, cce_pkg::OP_HALT: ctrl_cyc = cce_pkg::CTRL_CYC;
      cce_pkg::OP_IDLE: ctrl_cyc = cce_pkg::IDLE_CYC;
      default: is_ctrl = 1'b0;
    endcase
  end

  // memory operand cost: base, address calc, word surcharge
  assign mem_cyc = cce_pkg::MEM_OP_CYC + cce_pkg::EA_CYC + (opcode_r[0] ? cce_pkg::WORD_XFER_CYC : '0);

  // ****************
  // address and segment
  // ****************
  cce_ea_calc u_ea (
    .mode(mode_r),
    .rm(rm_r),
    .disp(disp_r),
    .reg_bx(reg_bx),
    .reg_bp(reg_bp),
    .reg_si(reg_si),
    .reg_di(reg_di),
    .ea(ea_calc),
    .uses_bp(ea_uses_bp)
  );

  // override wins, else stack for base pointer, else data
  always_comb begin
    if (ovr_valid_r) begin
      seg_pick = ovr_seg_r;
    end else if (ea_uses_bp) begin
      seg_pick = cce_pkg::SEG_STACK;
    end else begin
      seg_pick = cce_pkg::SEG_DATA;
    end
  end

  // ****************
  // cycle timer
  // ****************
  always_comb begin
    timer_load = 1'b0;
    timer_val = cce_pkg::CTRL_CYC;
    if (state_r == cce_pkg::ST_OPC && accept && is_ctrl) begin
      timer_load = 1'b1;
      timer_val = ctrl_cyc;
    end else if (state_r == cce_pkg::ST_OPC && accept && is_string) begin
      timer_load = 1'b1;
      timer_val = cce_pkg::MEM_OP_CYC + cce_pkg::WORD_XFER_CYC;
    end else if (state_r == cce_pkg::ST_CALC) begin
      timer_load = 1'b1;
      timer_val = (mode_r == cce_pkg::MOD_REG) ? cce_pkg::REG_OP_CYC : mem_cyc;
    end
  end

  cce_cycle_timer u_timer (
    .clock(clock),
    .arst_n(arst_n),
    .load(timer_load),
    .load_val(timer_val),
    .done(timer_done)
  );

  // ****************
  // sequencer
  // ****************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= cce_pkg::ST_OPC;
    end else begin
      case (state_r)
        cce_pkg::ST_OPC: begin
          if (accept && (is_ctrl || is_string)) begin
            state_r <= cce_pkg::ST_EXEC;
          end else if (accept && !is_seg_pfx) begin
            state_r <= cce_pkg::ST_MODRM;
          end
        end
        cce_pkg::ST_MODRM: begin
          if (accept && modrm_disp != 2'h0) begin
            state_r <= cce_pkg::ST_DLO;
          end else if (accept && is_imm_grp) begin
            state_r <= cce_pkg::ST_IMM;
          end else if (accept) begin
            state_r <= cce_pkg::ST_CALC;
          end
        end
        cce_pkg::ST_DLO: begin
          if (accept && disp_left_r == 2'h2) begin
            state_r <= cce_pkg::ST_DHI;
          end else if (accept) begin
            state_r <= is_imm_grp ? cce_pkg::ST_IMM : cce_pkg::ST_CALC;
          end
        end
        cce_pkg::ST_DHI: begin
          if (accept) begin
            state_r <= is_imm_grp ? cce_pkg::ST_IMM : cce_pkg::ST_CALC;
          end
        end
        cce_pkg::ST_IMM: begin
          if (accept && imm_left_r == 2'h1) begin
            state_r <= cce_pkg::ST_CALC;
          end
        end
        cce_pkg::ST_CALC: state_r <= cce_pkg::ST_EXEC;
        cce_pkg::ST_EXEC: begin
          if (timer_done) begin
            state_r <= cur_halt_r ? cce_pkg::ST_HALT : cce_pkg::ST_OPC;
          end
        end
        cce_pkg::ST_HALT: begin
          if (wake) begin
            state_r <= cce_pkg::ST_OPC;
          end
        end
        default: state_r <= cce_pkg::ST_OPC;
      endcase
    end
  end

  // fetch ready only in byte-taking states
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      byte_ready_r <= 1'b1;
    end else if (accept && state_r == cce_pkg::ST_OPC && (is_ctrl || is_string)) begin
      byte_ready_r <= 1'b0;
    end else if (accept && state_r == cce_pkg::ST_DHI) begin
      byte_ready_r <= is_imm_grp;
    end else if (accept && state_r == cce_pkg::ST_DLO && disp_left_r == 2'h1) begin
      byte_ready_r <= is_imm_grp;
    end else if (accept && state_r == cce_pkg::ST_MODRM && modrm_disp == 2'h0) begin
      byte_ready_r <= is_imm_grp;
    end else if (accept && state_r == cce_pkg::ST_IMM && imm_left_r == 2'h1) begin
      byte_ready_r <= 1'b0;
    end else if (state_r == cce_pkg::ST_EXEC && timer_done) begin
      byte_ready_r <= ~cur_halt_r;
    end else if (state_r == cce_pkg::ST_HALT && wake) begin
      byte_ready_r <= 1'b1;
    end
  end

  // ****************
  // instruction fields
  // ****************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      opcode_r <= 8'h00;
      mode_r <= cce_pkg::MOD_REG;
      rm_r <= 3'h0;
      regf_r <= 3'h0;
      disp_left_r <= 2'h0;
      imm_left_r <= 2'h0;
    end else if (accept) begin
      case (state_r)
        cce_pkg::ST_OPC: begin
          opcode_r <= byte_data;
          if (is_string) begin
            mode_r <= cce_pkg::MOD_NODISP;
          end
        end
        cce_pkg::ST_MODRM: begin
          mode_r <= byte_data[7:6];
          regf_r <= byte_data[5:3];
          rm_r <= byte_data[2:0];
          disp_left_r <= modrm_disp;
          imm_left_r <= imm_count;
        end
        cce_pkg::ST_IMM: imm_left_r <= imm_left_r - 2'h1;
        default: disp_left_r <= disp_left_r;
      endcase
    end
  end

  // displacement assembly
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      disp_r <= 16'h0000;
    end else if (accept && state_r == cce_pkg::ST_MODRM) begin
      disp_r <= 16'h0000;
    end else if (accept && state_r == cce_pkg::ST_DLO) begin
      disp_r <= {{8{byte_data[7] & (disp_left_r == 2'h1)}}, byte_data};
    end else if (accept && state_r == cce_pkg::ST_DHI) begin
      disp_r <= {byte_data, disp_r[7:0]};
    end
  end

  // ****************
  // prefixes
  // ****************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ovr_valid_r <= 1'b0;
      ovr_seg_r <= cce_pkg::SEG_DATA;
    end else if (accept && state_r == cce_pkg::ST_OPC && is_seg_pfx) begin
      ovr_valid_r <= 1'b1;
      ovr_seg_r <= byte_data[cce_pkg::SEG_PFX_LSB +: 2];
    end else if (state_r == cce_pkg::ST_EXEC && timer_done && !cur_lock_r) begin
      ovr_valid_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cur_lock_r <= 1'b0;
      cur_halt_r <= 1'b0;
    end else if (accept && state_r == cce_pkg::ST_OPC) begin
      cur_lock_r <= (byte_data == cce_pkg::OP_LOCK);
      cur_halt_r <= (byte_data == cce_pkg::OP_HALT);
    end
  end

  // lock holds through the next instruction
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lock_pend_r <= 1'b0;
      bus_lock_r <= 1'b0;
    end else if (state_r == cce_pkg::ST_EXEC && timer_done) begin
      lock_pend_r <= cur_lock_r;
      bus_lock_r <= cur_lock_r;
    end else if (accept && state_r == cce_pkg::ST_OPC && !is_seg_pfx) begin
      bus_lock_r <= lock_pend_r | (byte_data == cce_pkg::OP_LOCK);
    end
  end

  // ****************
  // flags
  // ****************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      carry_r <= 1'b0;
      direction_r <= 1'b0;
      irq_enable_r <= 1'b0;
    end else if (accept && state_r == cce_pkg::ST_OPC) begin
      case (byte_data)
        cce_pkg::OP_CARRY_CLEAR: carry_r <= 1'b0;
        cce_pkg::OP_CARRY_INVERT: carry_r <= ~carry_r;
        cce_pkg::OP_CARRY_SET: carry_r <= 1'b1;
        cce_pkg::OP_DIR_CLEAR: direction_r <= 1'b0;
        cce_pkg::OP_DIR_SET: direction_r <= 1'b1;
        cce_pkg::OP_IRQ_CLEAR: irq_enable_r <= 1'b0;
        cce_pkg::OP_IRQ_SET: irq_enable_r <= 1'b1;
        default: carry_r <= carry_r;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      halted_r <= 1'b0;
    end else if (state_r == cce_pkg::ST_EXEC && timer_done) begin
      halted_r <= cur_halt_r;
    end else if (state_r == cce_pkg::ST_HALT && wake) begin
      halted_r <= 1'b0;
    end
  end

  // ****************
  // operand outputs
  // ****************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mem_operand_r <= 1'b0;
      ea_r <= 16'h0000;
      seg_r <= cce_pkg::SEG_DATA;
      reg_sel_r <= 4'h0;
      rm_reg_sel_r <= 4'h0;
    end else if (accept && state_r == cce_pkg::ST_OPC && is_string) begin
      mem_operand_r <= 1'b1;
      ea_r <= reg_di;
      seg_r <= cce_pkg::SEG_EXTRA;
    end else if (state_r == cce_pkg::ST_CALC) begin
      mem_operand_r <= (mode_r != cce_pkg::MOD_REG);
      ea_r <= ea_calc;
      seg_r <= seg_pick;
      reg_sel_r <= decode_reg(opcode_r[0], regf_r);
      rm_reg_sel_r <= decode_reg(opcode_r[0], rm_r);
    end
  end

  // completion pulse and cost report
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      op_done_r <= 1'b0;
      op_cycles_r <= '0;
    end else begin
      op_done_r <= (state_r == cce_pkg::ST_EXEC) && timer_done;
      if (timer_load) begin
        op_cycles_r <= timer_val;
      end
    end
  end

  assign byte_ready = byte_ready_r;
  assign carry_flag = carry_r;
  assign direction_flag = direction_r;
  assign irq_enable_flag = irq_enable_r;
  assign halted = halted_r;
  assign bus_lock = bus_lock_r;
  assign op_done = op_done_r;
  assign op_cycles = op_cycles_r;
  assign mem_operand = mem_operand_r;
  assign effective_address = ea_r;
  assign segment_sel = seg_r;
  assign reg_sel = reg_sel_r;
  assign rm_reg_sel = rm_reg_sel_r;
endmodule : cce_decode

// *** testbench/cce_decode_assertions.sv ***
// ****************
// checker on the decoder ports
// ****************
module cce_chk (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic byte_ready,
  input wire logic wake,
  input wire logic carry_flag,
  input wire logic direction_flag,
  input wire logic irq_enable_flag,
  input wire logic halted,
  input wire logic bus_lock,
  input wire logic op_done,
  input wire logic [cce_pkg::CW-1:0] op_cycles
);
  timeunit 1ns;
  timeprecision 1ps;
  logic fresh_r;
  logic opc_take;
  logic is_pfx;
  // opcode phase tracker, prefixes keep the phase
  assign is_pfx = ((byte_data & cce_pkg::SEG_PFX_MASK) == cce_pkg::SEG_PFX_VAL) || (byte_data == cce_pkg::OP_LOCK);
  assign opc_take = byte_valid && byte_ready && (fresh_r || op_done);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fresh_r <= 1'b1;
    end else if (opc_take && !is_pfx) begin
      fresh_r <= 1'b0;
    end else if (op_done) begin
      fresh_r <= 1'b1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence ctrl_take;
    opc_take && (byte_data inside {8'hF8, 8'hF5, 8'hF9, 8'hFC, 8'hFD, 8'hFA, 8'hFB, 8'hF4});
  endsequence
  sequence two_quiet;
    !op_done ##1 !op_done;
  endsequence
  chk_ctrl_timing: assert property (ctrl_take |=> two_quiet ##1 (op_done && op_cycles == cce_pkg::CTRL_CYC))
    else $error("control op finish time wrong");
  chk_idle_timing: assert property (opc_take && byte_data == cce_pkg::OP_IDLE |=> !op_done ##1 two_quiet ##1
    (op_done && op_cycles == cce_pkg::IDLE_CYC))
    else $error("idle op finish time wrong");
  chk_ctrl_busy: assert property (ctrl_take |=> !byte_ready [*2])
    else $error("byte taken during control op");
  chk_carry_setclr: assert property (opc_take && byte_data inside {8'hF8, 8'hF9} |=> carry_flag == $past(byte_data[0]))
    else $error("carry set or clear wrong");
  chk_carry_invert: assert property (opc_take && byte_data == cce_pkg::OP_CARRY_INVERT |=> carry_flag != $past(carry_flag))
    else $error("carry not inverted");
  chk_dir_ops: assert property (opc_take && byte_data inside {8'hFC, 8'hFD} |=> direction_flag == $past(byte_data[0]))
    else $error("direction flag wrong");
  chk_irq_ops: assert property (opc_take && byte_data inside {8'hFA, 8'hFB} |=> irq_enable_flag == $past(byte_data[0]))
    else $error("irq enable flag wrong");
  chk_halt_enter: assert property (opc_take && byte_data == cce_pkg::OP_HALT |-> ##[1:4] halted)
    else $error("halt not entered");
  chk_halt_stay: assert property (halted && !wake |=> halted && !byte_ready)
    else $error("halt left without wake");
  chk_lock_cause: assert property (opc_take && byte_data == cce_pkg::OP_LOCK |-> ##[1:3] bus_lock)
    else $error("bus lock not raised");
endmodule : cce_chk

// *** testbench/tb.sv ***
// ****************
// self-checking bench for the decoder
// ****************
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CMP_VAL(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value at %0t: %h vs %h", $time, g, e); end end
  typedef struct {logic [1:0] what; logic [2:0] flg; logic [5:0] cyc; logic [15:0] ea; logic [1:0] seg;
    logic [3:0] rs; logic [3:0] rms;} cce_note_s;
  logic clock = 1'b0, arst_n = 1'b0, byte_valid = 1'b0, wake = 1'b0;
  logic [7:0] byte_data = 8'h00;
  logic [15:0] reg_bx = 16'h0000, reg_bp = 16'h0000, reg_si = 16'h0000, reg_di = 16'h0000;
  logic byte_ready, carry_flag, direction_flag, irq_enable_flag, halted, bus_lock, op_done, mem_operand;
  logic [cce_pkg::CW-1:0] op_cycles;
  logic [15:0] effective_address;
  logic [1:0] segment_sel;
  logic [3:0] reg_sel, rm_reg_sel;
  int err_total = 0, checks_done = 0, seed = 32'hED50, cyc = 0;
  logic cf_m = 1'b0, df_m = 1'b0, if_m = 1'b0;
  cce_note_s notes[$];
  cce_note_s mon_n;
  logic [7:0] ctab [9] = '{cce_pkg::OP_CARRY_CLEAR, cce_pkg::OP_CARRY_INVERT, cce_pkg::OP_CARRY_SET,
    cce_pkg::OP_DIR_CLEAR, cce_pkg::OP_DIR_SET, cce_pkg::OP_IRQ_CLEAR, cce_pkg::OP_IRQ_SET, cce_pkg::OP_LOCK,
    cce_pkg::OP_IDLE};
  logic [7:0] stab [8] = '{8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'hAA, 8'hAB, 8'hAE, 8'hAF};
  cce_decode dut (.clock(clock), .arst_n(arst_n), .byte_valid(byte_valid), .byte_data(byte_data),
    .reg_bx(reg_bx), .reg_bp(reg_bp), .reg_si(reg_si), .reg_di(reg_di), .wake(wake), .byte_ready(byte_ready),
    .carry_flag(carry_flag), .direction_flag(direction_flag), .irq_enable_flag(irq_enable_flag),
    .halted(halted), .bus_lock(bus_lock), .op_done(op_done), .op_cycles(op_cycles), .mem_operand(mem_operand),
    .effective_address(effective_address), .segment_sel(segment_sel), .reg_sel(reg_sel),
    .rm_reg_sel(rm_reg_sel));
  // ****************
  // clock, watchdog, verdict
  // ****************
  initial forever #2 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  // ****************
  // drivers
  // ****************
  task automatic put(input logic [7:0] b);
    @(negedge clock);
    byte_valid = 1'b1;
    byte_data = b;
    do @(posedge clock); while (byte_ready !== 1'b1);
  endtask : put
  // drop the byte and wait for the instruction to finish
  task automatic release_op();
    @(negedge clock);
    byte_valid = 1'b0;
    byte_data = 8'($random(seed));
    do @(negedge clock); while (op_done !== 1'b1);
  endtask : release_op
  task automatic note(input logic [1:0] what, input logic [5:0] c, input logic [15:0] ea, input logic [1:0] sg,
    input logic [3:0] rs, input logic [3:0] rms);
    cce_note_s n;
    n = '{what, {cf_m, df_m, if_m}, c, ea, sg, rs, rms};
    notes.push_back(n);
  endtask : note
  task automatic ctrl(input logic [7:0] op);
    if (op inside {8'hF8, 8'hF9}) cf_m = op[0];
    else if (op == cce_pkg::OP_CARRY_INVERT) cf_m = ~cf_m;
    else if (op inside {8'hFC, 8'hFD}) df_m = op[0];
    else if (op inside {8'hFA, 8'hFB}) if_m = op[0];
    note(2'h0, (op == cce_pkg::OP_IDLE) ? cce_pkg::IDLE_CYC : cce_pkg::CTRL_CYC, 16'h0000, 2'h0, 4'h0, 4'h0);
    put(op);
    release_op();
  endtask : ctrl
  task automatic mem_op(input logic pf, input logic [1:0] ps, input logic [7:0] opc, input logic [1:0] md,
    input logic [2:0] rg, input logic [2:0] rm);
    logic [15:0] d, ea;
    logic [1:0] sg;
    logic [7:0] lo, hi;
    lo = 8'($random(seed));
    hi = 8'($random(seed));
    reg_bx = 16'($random(seed));
    reg_bp = 16'($random(seed));
    reg_si = 16'($random(seed));
    reg_di = 16'($random(seed));
    d = (md == 2'h1) ? {{8{lo[7]}}, lo} : (md == 2'h2) ? {hi, lo} : 16'h0000;
    case (rm)
      3'h0: ea = reg_bx + reg_si + d;
      3'h1: ea = reg_bx + reg_di + d;
      3'h2: ea = reg_bp + reg_si + d;
      3'h3: ea = reg_bp + reg_di + d;
      3'h4: ea = reg_si + d;
      3'h5: ea = reg_di + d;
      3'h6: ea = (md == 2'h0) ? {hi, lo} : reg_bp + d;
      default: ea = reg_bx + d;
    endcase
    sg = (rm inside {3'h2, 3'h3} || (rm == 3'h6 && md != 2'h0)) ? cce_pkg::SEG_STACK : cce_pkg::SEG_DATA;
    if (pf) sg = ps;
    if (md == 2'h3) note(2'h1, cce_pkg::REG_OP_CYC, 16'h0000, 2'h0, {~opc[0], rg}, {~opc[0], rm});
    else note(2'h3, cce_pkg::MEM_OP_CYC + cce_pkg::EA_CYC + (opc[0] ? cce_pkg::WORD_XFER_CYC : 6'h00), ea, sg,
      {~opc[0], rg}, 4'h0);
    if (pf) put(8'h26 | {3'h0, ps, 3'h0});
    put(opc);
    put({md, rg, rm});
    if (md == 2'h1) put(lo);
    else if (md == 2'h2 || (md == 2'h0 && rm == 3'h6)) begin
      put(lo);
      put(hi);
    end
    if (opc[7:2] == 6'h20) begin
      put(~lo);
      if (opc[1:0] == 2'h1) put(~hi);
    end
    release_op();
  endtask : mem_op
  // ****************
  // result monitor
  // ****************
  always @(negedge clock) begin
    if (op_done === 1'b1) begin
      if (notes.size() == 0) begin
        err_total++;
        $display("wrong value at %0t: %h vs %h", $time, op_done, 1'b0);
      end else begin
        mon_n = notes.pop_front();
        `CMP_VAL({carry_flag, direction_flag, irq_enable_flag}, mon_n.flg)
        `CMP_VAL(op_cycles, mon_n.cyc)
        if (mon_n.what[0]) `CMP_VAL(reg_sel, mon_n.rs)
        if (mon_n.what == 2'h1) `CMP_VAL({mem_operand, rm_reg_sel}, {1'b0, mon_n.rms})
        if (mon_n.what[1]) `CMP_VAL({mem_operand, effective_address, segment_sel}, {1'b1, mon_n.ea, mon_n.seg})
      end
    end
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (16) @(negedge clock);
    arst_n = 1'b1;
    for (int i = 0; i < 27; i++) ctrl((i < 9) ? ctab[i] : ctab[$unsigned($random(seed)) % 9]);
    $display("test control ops done");
    ctrl(cce_pkg::OP_HALT);
    repeat (5) @(negedge clock);
    `CMP_VAL({halted, byte_ready}, 2'h2)
    wake = 1'b1;
    @(negedge clock);
    wake = 1'b0;
    do @(negedge clock); while (byte_ready !== 1'b1);
    `CMP_VAL(halted, 1'b0)
    $display("test halt done");
    for (int k = 0; k < 16; k++) mem_op(1'b0, 2'h0, 8'h88 | {7'h00, k[3]}, 2'h3, k[2:0], ~k[2:0]);
    $display("test register operands done");
    for (int m = 0; m < 3; m++) begin
      for (int r = 0; r < 8; r++) mem_op(1'b0, 2'h0, 8'h88 | 8'($random(seed) & 1), m[1:0], 3'($random(seed)), r[2:0]);
    end
    $display("test address modes done");
    for (int s = 0; s < 4; s++) begin
      mem_op(1'b1, s[1:0], 8'h8B, 2'h1, 3'h2, 3'h2);
      mem_op(1'b0, 2'h0, 8'h8B, 2'h1, 3'h2, 3'h3);
    end
    mem_op(1'b0, 2'h0, 8'h81, 2'h2, 3'h0, 3'h7);
    mem_op(1'b0, 2'h0, 8'h83, 2'h1, 3'h5, 3'h4);
    mem_op(1'b0, 2'h0, 8'h80, 2'h0, 3'h1, 3'h6);
    $display("test overrides and immediates done");
    for (int i = 0; i < 8; i++) begin
      reg_di = 16'($random(seed));
      note(2'h2, cce_pkg::MEM_OP_CYC + cce_pkg::EA_CYC, reg_di, cce_pkg::SEG_EXTRA, 4'h0, 4'h0);
      if (i[0]) put(8'h3E);
      put(stab[i]);
      release_op();
    end
    $display("test string destinations done");
    results();
  end
endmodule : tb
bind cce_decode cce_chk u_chk (.clock(clock), .arst_n(arst_n), .byte_valid(byte_valid), .byte_data(byte_data),
  .byte_ready(byte_ready), .wake(wake), .carry_flag(carry_flag), .direction_flag(direction_flag),
  .irq_enable_flag(irq_enable_flag), .halted(halted), .bus_lock(bus_lock), .op_done(op_done),
  .op_cycles(op_cycles));
